// >>> spp_host_port.sv
// Parallel host port: conventional two-word reads, modulator streaming,
// two-step register writes and register readback.
// Assumes host pins are asynchronous to SYS_CLK; conversion data arrives as pulses.
`timescale 1ns/10ps
module spp_host_port #(
  parameter int VALID_DLY = spp_pkg::VALID_DLY_DEF
) (
  // Clock and reset
  input  wire logic                       SYS_CLK,
  input  wire logic                       RESET_N,
  // Host bus pins
  input  wire logic                       CS_N,
  input  wire logic                       RD_WR_N,
  input  wire logic [15:0]                DATA_IN,
  output logic      [15:0]                DATA_OUT,
  output logic                            DATA_OE,
  output logic                            RESULT_STROBE_N,
  // Converter side
  input  wire logic                       RESULT_LOAD,
  input  wire logic [23:0]                RESULT_DATA,
  input  wire logic                       MOD_MODE,
  input  wire logic                       MOD_LOAD,
  input  wire logic [15:0]                MOD_DATA,
  input  wire spp_pkg::spp_flags_t        FLAGS_IN,
  input  wire logic [15:0]                READBACK_DATA,
  // Register write port to the register map
  output logic                            REG_WR,
  output logic [7:0]                      REG_ADDR,
  output logic [15:0]                     REG_WDATA,
  output logic [15:0]                     CTRL_REG,
  output logic                            INTERNAL_CLOCK_TICK
);
  // Refuse a valid delay that the counter cannot express
  if (VALID_DLY < 1) begin : g_bad_dly
    $error("VALID_DLY must be at least one");
  end

  // Pin synchronisers
  logic [1:0]  cs_sync_r;
  logic [1:0]  rd_sync_r;
  logic [15:0] din_s1_r;
  logic [15:0] din_s2_r;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cs_sync_r <= 2'h3;
      rd_sync_r <= 2'h3;
      din_s1_r  <= 16'h0000;
      din_s2_r  <= 16'h0000;
    end else begin
      cs_sync_r <= {cs_sync_r[0], CS_N};
      rd_sync_r <= {rd_sync_r[0], RD_WR_N};
      din_s1_r  <= DATA_IN;
      din_s2_r  <= din_s1_r;
    end
  end

  logic cs_n_s;
  logic rd_s;
  assign cs_n_s = cs_sync_r[1];
  assign rd_s   = rd_sync_r[1];

  // Internal clock derived from the master clock
  logic tick;
  spp_internal_clock_gen u_internal_clock (
    .sys_clk       (SYS_CLK),
    .reset_n       (RESET_N),
    .clock_halve_n (CTRL_REG[spp_pkg::CTRL_HALVE_BIT]),
    .internal_clock_tick     (tick)
  );

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) INTERNAL_CLOCK_TICK <= 1'b0;
    else          INTERNAL_CLOCK_TICK <= tick;
  end

  // Sampled pin state, updated only on internal clock ticks so every
  // timing check counts internal clock periods, not master cycles
  logic cs_n_r;
  logic rd_r;
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cs_n_r <= 1'b1;
      rd_r   <= 1'b1;
    end else if (tick) begin
      cs_n_r <= cs_n_s;
      rd_r   <= rd_s;
    end
  end

  logic read_act;
  logic write_act;
  assign read_act  = !cs_n_r && !rd_r;
  assign write_act = !cs_n_r && rd_r;

  // Bus state machine: which word a read returns, or a write in progress
  spp_pkg::spp_state_t state_r;
  spp_pkg::spp_state_t state_nxt;

  // Conversion result and status captured on each load
  logic [23:0]         result_r;
  spp_pkg::spp_flags_t flags_r;
  logic [7:0]          status_byte;
  // Low word goes out next; a fresh result clears it, so a slow host never pairs
  // the halves of two conversions, unless the result lands during a high-word read
  logic                lo_next_r;

  // Register write path
  logic [7:0]          addr_r;
  logic                addr_pend_r;
  logic [2:0]          wr_cnt_r;
  logic                wr_done_r;

  // Readback requests left by a control write
  logic                rdbk_pend_r;
  logic                stat_pend_r;

  // Valid delay counter, counted in internal clock ticks
  localparam int       VCNT_W = $clog2(VALID_DLY + 1);
  logic [VCNT_W-1:0]   vcnt_r;
  logic                data_ready;

  // Events of this cycle
  logic                stream_act;
  logic                conv_load;
  logic                mod_load;
  logic                read_start;
  logic                read_end;
  logic                wr_take;
  logic                reg_commit;
  logic                ctrl_wr;

  // Streaming needs modulator mode and a read held on both pins
  assign stream_act = MOD_MODE && read_act;
  // A result load is ignored in modulator mode; the modulator owns the bus then
  assign conv_load  = !MOD_MODE && RESULT_LOAD;
  assign mod_load   = stream_act && MOD_LOAD;
  // Read edges as seen by the state machine
  assign read_start = (state_r == spp_pkg::SPP_IDLE) && read_act && !MOD_MODE;
  assign read_end   = ((state_r == spp_pkg::SPP_RD_HI) || (state_r == spp_pkg::SPP_RD_LO)) && !read_act;
  // The bus word is taken once, on the tick that completes the low time
  assign wr_take    = (state_r == spp_pkg::SPP_WR) && write_act && tick && !wr_done_r &&
                      (wr_cnt_r == (spp_pkg::WR_MIN_INTERNAL_CLOCK - 3'h1));
  // A taken word is data when an address is already pending
  assign reg_commit = wr_take && addr_pend_r;
  assign ctrl_wr    = reg_commit && (addr_r == spp_pkg::CTRL_ADDR);

  // Next state; reads and writes differ only in read-not-write, sampled
  // on the internal clock like chip select
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      spp_pkg::SPP_IDLE: begin
        if (read_act && !MOD_MODE) begin
          if (lo_next_r && !rdbk_pend_r && !stat_pend_r) begin
            state_nxt = spp_pkg::SPP_RD_LO;
          end else begin
            state_nxt = spp_pkg::SPP_RD_HI;
          end
        end else if (write_act) begin
          state_nxt = spp_pkg::SPP_WR;
        end
      end
      spp_pkg::SPP_RD_HI: begin
        if (!read_act) begin
          state_nxt = spp_pkg::SPP_IDLE;
        end
      end
      spp_pkg::SPP_RD_LO: begin
        if (!read_act) begin
          state_nxt = spp_pkg::SPP_IDLE;
        end
      end
      spp_pkg::SPP_WR: begin
        if (!write_act) begin
          state_nxt = spp_pkg::SPP_IDLE;
        end
      end
      default: begin
        state_nxt = spp_pkg::SPP_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= spp_pkg::SPP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Each new result overwrites the output register, even in mid-read;
  // the valid flag is masked until the filter delay has run out
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      result_r <= 24'h000000;
      flags_r  <= '0;
    end else if (conv_load) begin
      result_r              <= RESULT_DATA;
      flags_r.valid         <= FLAGS_IN.valid && data_ready;
      flags_r.overrange     <= FLAGS_IN.overrange;
      flags_r.unfiltered    <= FLAGS_IN.unfiltered;
      flags_r.low_power     <= FLAGS_IN.low_power;
      flags_r.filter_good   <= FLAGS_IN.filter_good;
      flags_r.download_good <= FLAGS_IN.download_good;
    end
  end

  // Status byte of the low word; the two lowest bits stay zero
  always_comb begin
    status_byte                     = 8'h00;
    status_byte[spp_pkg::ST_VALID]  = flags_r.valid;
    status_byte[spp_pkg::ST_OVR]    = flags_r.overrange;
    status_byte[spp_pkg::ST_UNFILT] = flags_r.unfiltered;
    status_byte[spp_pkg::ST_LOWPWR] = flags_r.low_power;
    status_byte[spp_pkg::ST_FILTER_GOOD_FLAG] = flags_r.filter_good;
    status_byte[spp_pkg::ST_DOWNLOAD_GOOD_FLAG]   = flags_r.download_good;
  end

  // Word pointer: high word after a load, low word after the high one
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lo_next_r <= 1'b0;
    end else if (conv_load) begin
      lo_next_r <= 1'b0;
    end else if (read_end && (state_r == spp_pkg::SPP_RD_HI) && !rdbk_pend_r && !stat_pend_r) begin
      lo_next_r <= 1'b1;
    end else if (read_end && (state_r == spp_pkg::SPP_RD_LO)) begin
      lo_next_r <= 1'b0;
    end
  end

  // Bus word; the high half goes first, readback words replace a result
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DATA_OUT <= 16'h0000;
    end else if (mod_load) begin
      DATA_OUT <= MOD_DATA;
    end else if (read_start) begin
      if (rdbk_pend_r) begin
        DATA_OUT <= READBACK_DATA;
      end else if (stat_pend_r) begin
        DATA_OUT <= {8'h00, status_byte};
      end else if (lo_next_r) begin
        DATA_OUT <= {result_r[7:0], status_byte};
      end else begin
        DATA_OUT <= result_r[23:8];
      end
    end
  end

  // Drive starts from the tick-sampled read but ends on the raw synchronised
  // pins, so the bus floats three clocks after select or read-not-write rises
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DATA_OE <= 1'b0;
    end else begin
      DATA_OE <= read_act && !cs_n_s && !rd_s;
    end
  end

  // Strobe falls with each new word and rises on the next internal tick;
  // the word is already settled, so it is valid at the rising edge
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RESULT_STROBE_N <= 1'b1;
    end else if (conv_load || mod_load) begin
      RESULT_STROBE_N <= 1'b0;
    end else if (tick) begin
      RESULT_STROBE_N <= 1'b1;
    end
  end

  // Low time of a write, in internal clock ticks; saturates at the minimum
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_cnt_r  <= 3'h0;
      wr_done_r <= 1'b0;
    end else if (state_r != spp_pkg::SPP_WR) begin
      wr_cnt_r  <= 3'h0;
      wr_done_r <= 1'b0;
    end else if (tick && write_act) begin
      if (wr_cnt_r != spp_pkg::WR_MIN_INTERNAL_CLOCK) begin
        wr_cnt_r <= wr_cnt_r + 3'h1;
      end
      if (wr_take) begin
        wr_done_r <= 1'b1;
      end
    end
  end

  // Address step; a read in between drops a pending address, which also
  // lets a host that lost count start over
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      addr_r      <= 8'h00;
      addr_pend_r <= 1'b0;
    end else if (read_act) begin
      addr_pend_r <= 1'b0;
    end else if (wr_take && !addr_pend_r) begin
      addr_r      <= din_s2_r[7:0];
      addr_pend_r <= 1'b1;
    end else if (wr_take) begin
      addr_pend_r <= 1'b0;
    end
  end

  // Register write strobe to the register map, one master cycle wide
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_WR    <= 1'b0;
      REG_ADDR  <= 8'h00;
      REG_WDATA <= 16'h0000;
    end else begin
      REG_WR <= reg_commit;
      if (reg_commit) begin
        REG_ADDR  <= addr_r;
        REG_WDATA <= din_s2_r;
      end
    end
  end

  // Control register; the reset value leaves the internal clock halved
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CTRL_REG <= spp_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      CTRL_REG <= din_s2_r;
    end
  end

  // Readback requests; each serves only the next read
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdbk_pend_r <= 1'b0;
      stat_pend_r <= 1'b0;
    end else if (ctrl_wr) begin
      rdbk_pend_r <= din_s2_r[spp_pkg::CTRL_RDBK_BIT];
      stat_pend_r <= din_s2_r[spp_pkg::CTRL_STAT_BIT];
    end else if (read_end) begin
      rdbk_pend_r <= 1'b0;
      stat_pend_r <= 1'b0;
    end
  end

  // Valid delay restarts on every taken write word, so results stay marked
  // invalid until the filter has settled on the new settings
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      vcnt_r <= '0;
    end else if (wr_take) begin
      vcnt_r <= '0;
    end else if (tick && !data_ready) begin
      vcnt_r <= vcnt_r + 1'b1;
    end
  end

  // Ready once the full valid delay has been counted
  assign data_ready = (vcnt_r == VCNT_W'(VALID_DLY));
endmodule

// >>> spp_pkg.sv
// Package for the sigma-delta converter's parallel host port
// Assumes SYS_CLK at 50 MHz stands in for the master clock
package spp_pkg;
  localparam int          DATA_W          = 16;
  localparam int          RESULT_W        = 24;
  localparam int          ADDR_W          = 8;
  // Write must hold select low this many internal clock periods
  localparam logic [2:0]  WR_MIN_INTERNAL_CLOCK     = 3'h4;
  // Control register address and bit positions
  localparam logic [7:0]  CTRL_ADDR       = 8'h01;
  localparam int          CTRL_HALVE_BIT  = 3;
  localparam int          CTRL_RDBK_BIT   = 4;
  localparam int          CTRL_STAT_BIT   = 5;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  // Status byte positions inside the low result word
  localparam int          ST_VALID        = 7;
  localparam int          ST_OVR          = 6;
  localparam int          ST_UNFILT       = 5;
  localparam int          ST_LOWPWR       = 4;
  localparam int          ST_FILTER_GOOD_FLAG       = 3;
  localparam int          ST_DOWNLOAD_GOOD_FLAG         = 2;
  // Default valid delay in internal clocks (2x filter + computation delay)
  localparam int          VALID_DLY_DEF   = 32'd4096;

  typedef enum logic [1:0] {
    SPP_IDLE  = 2'b00,
    SPP_RD_HI = 2'b01,
    SPP_RD_LO = 2'b10,
    SPP_WR    = 2'b11
  } spp_state_t;

  // Status flags as they ride the low result word
  typedef struct packed {
    logic valid;
    logic overrange;
    logic unfiltered;
    logic low_power;
    logic filter_good;
    logic download_good;
  } spp_flags_t;
endpackage

// >>> spp_internal_clock_gen.sv
// Internal clock enable generator for the host port
// Assumes master clock is SYS_CLK; the halve select is a registered level
`timescale 1ns/10ps
module spp_internal_clock_gen (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Control
  input  wire logic clock_halve_n,
  // Internal clock tick, one master cycle wide at half rate, held high every cycle at full rate
  output logic      internal_clock_tick
);
  logic phase_r;

  // Full rate when halve bit is 1, every other master cycle when 0
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r   <= 1'b0;
      internal_clock_tick <= 1'b0;
    end else begin
      phase_r   <= ~phase_r;
      internal_clock_tick <= clock_halve_n | phase_r;
    end
  end
endmodule

// >>> spp_host.sv
// Host model: settles the data lines, latches streamed words
// Assumes the bench drives the host's half of the bus
`timescale 1ns/10ps
module spp_host (
  // Both drivers and the strobe
  input  wire logic        dev_oe,
  input  wire logic [15:0] dev_q,
  input  wire logic        host_oe,
  input  wire logic [15:0] host_q,
  input  wire logic        stb_n,
  // Wire level and latched word
  output logic      [15:0] bus,
  output logic      [15:0] word
);
  // No pulls: a floating bus reads inverted, never as a stale copy
  assign bus = dev_oe ? dev_q : host_oe ? host_q : ~dev_q;
  // Words are taken on the strobe's rising edge, as a FIFO would
  always_ff @(posedge stb_n) word <= bus;
endmodule

// >>> spp_host_port_asserts.sv
// Checker on the host port pins
// Assumes it is bound onto spp_host_port
`timescale 1ns/10ps
module spp_chk (
  // Clock, reset and pins
  input wire logic        SYS_CLK,
  input wire logic        RESET_N,
  input wire logic        CS_N,
  input wire logic        RD_WR_N,
  input wire logic        DATA_OE,
  input wire logic        RESULT_STROBE_N,
  input wire logic        REG_WR,
  input wire logic        INTERNAL_CLOCK_TICK,
  input wire logic [15:0] CTRL_REG
);
  localparam int H = spp_pkg::CTRL_HALVE_BIT;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  // Pins are asynchronous, so a few cycles of sync lag are allowed
  a_idle_float: assert property (CS_N [*4] |-> !DATA_OE) else $error("oe idle");
  a_write_float: assert property (RD_WR_N [*4] |-> !DATA_OE) else $error("oe wr");
  a_read_drive: assert property ((!CS_N && !RD_WR_N) [*6] |-> DATA_OE) else $error("no oe");
  a_reset_half: assert property ($rose(RESET_N) |-> !CTRL_REG[H]) else $error("div");
  a_half_tick: assert property ((!CTRL_REG[H]) [*4] |-> INTERNAL_CLOCK_TICK != $past(INTERNAL_CLOCK_TICK)) else $error("d2");
  a_full_tick: assert property (CTRL_REG[H] [*4] |-> INTERNAL_CLOCK_TICK) else $error("d1");
  a_strobe_short: assert property ($fell(RESULT_STROBE_N) |-> ##[1:7] RESULT_STROBE_N) else $error("stb");
  a_wr_pulse: assert property (REG_WR |=> !REG_WR) else $error("wr");
  c_read: cover property ($fell(DATA_OE));
  c_write: cover property (REG_WR);
  c_stream: cover property ($rose(RESULT_STROBE_N) && DATA_OE);
endmodule
bind spp_host_port spp_chk spp_chk_i (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CS_N(CS_N), .RD_WR_N(RD_WR_N),
  .DATA_OE(DATA_OE), .RESULT_STROBE_N(RESULT_STROBE_N), .REG_WR(REG_WR), .INTERNAL_CLOCK_TICK(INTERNAL_CLOCK_TICK), .CTRL_REG(CTRL_REG));

// >>> adc_parallel_host_port_tb_top.sv
// Bench for the host port: reads, writes, readback, streaming
// Assumes spp_pkg, spp_host_port and spp_host compile first
`timescale 1ns/10ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, s); end end
module adc_parallel_host_port_tb_top;
  logic                clk = 0, rst_n = 0, cs_n = 1, rw_n = 1, hoe = 0, rl = 0, mm = 0, ml = 0, oe, stb;
  logic         [15:0] hq = '0, md = '0, rb = '0, v, dq, bus, word, ctrl, wd;
  logic         [23:0] rd = '0;
  logic         [7:0]  ra;
  spp_pkg::spp_flags_t fl = '0;
  int                  error_cnt = 0, total_checks = 0, seed = 32'h367C9E96, w;
  spp_host_port #(.VALID_DLY(16)) spp_host_port_i (
    .SYS_CLK(clk), .RESET_N(rst_n), .CS_N(cs_n), .RD_WR_N(rw_n), .DATA_IN(bus), .DATA_OUT(dq),
    .DATA_OE(oe), .RESULT_STROBE_N(stb), .RESULT_LOAD(rl), .RESULT_DATA(rd), .MOD_MODE(mm),
    .MOD_LOAD(ml), .MOD_DATA(md), .FLAGS_IN(fl), .READBACK_DATA(rb), .REG_WR(), .REG_ADDR(ra),
    .REG_WDATA(wd), .CTRL_REG(ctrl), .INTERNAL_CLOCK_TICK());
  spp_host spp_host_i (.dev_oe(oe), .dev_q(dq), .host_oe(hoe), .host_q(hq), .stb_n(stb), .bus(bus), .word(word));
  always #10 clk = ~clk;
  // Pins move at the falling edge and are held whole cycles
  task automatic pins(input logic c, r, input int n);
    cs_n = c;
    rw_n = r;
    repeat (n) @(negedge clk);
  endtask
  // Ten-cycle phases cover four internal clocks even at half rate
  task automatic wrw(input logic [15:0] d);
    hq = d;
    hoe = 1;
    pins(0, 1, 10);
    pins(1, 1, 10);
    hoe = 0;
  endtask
  task automatic rdw();
    pins(0, 0, 8);
    v = bus;
    pins(1, 1, 4);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // The run needs about 300 cycles; the 10000-cycle limit, over thirty times that, means a hang
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1;
    repeat (60) @(negedge clk);
    `CHK("ctrl", spp_pkg::CTRL_RESET, ctrl)
    for (int i = 0; i < 4; i++) begin
      rd = 24'($random(seed));
      fl = 6'($random(seed));
      rl = 1;
      @(negedge clk);
      rl = 0;
      for (w = 0; w < 40 && stb !== 1'b0; w++) @(negedge clk);
      `CHK("strobe", 1'b0, stb)
      rdw();
      `CHK("msw", rd[23:8], v)
      rdw();
      `CHK("lsw", {rd[7:0], fl, 2'b00}, v)
    end
    // A read after a lone address write must drop that address
    wrw(16'($random(seed)));
    rdw();
    wrw({8'h00, spp_pkg::CTRL_ADDR});
    wrw(16'h0018);
    `CHK("ctrl", 16'h0018, ctrl)
    `CHK("reg_addr", spp_pkg::CTRL_ADDR, ra)
    `CHK("reg_wdata", 16'h0018, wd)
    rb = 16'($random(seed));
    rdw();
    `CHK("readback", rb, v)
    mm = 1;
    pins(0, 0, 6);
    repeat (4) begin
      md = 16'($random(seed));
      ml = 1;
      @(negedge clk);
      ml = 0;
      repeat (5) @(negedge clk);
      `CHK("stream", md, word)
    end
    pins(1, 1, 6);
    `CHK("float", 1'b0, oe)
    end_of_test();
  end
endmodule
